// >>> rtl/spm_cfg.svh
// offsets, fields, resets and timing of the power-mode controller
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define SPM_OFS_PWR_STATE_CFG   8'h00
`define SPM_OFS_SENSOR_PWR_EN   8'h04
`define SPM_OFS_ACCEL_CFG       8'h08
`define SPM_OFS_FEAT_LOAD_CTRL  8'h0C
`define SPM_OFS_FEAT_WINDOW     8'h10
`define SPM_OFS_FEAT_INDEX      8'h14
`define SPM_OFS_ENGINE_STATUS   8'h18
`define SPM_OFS_TIME_COUNTER    8'h1C
`define SPM_OFS_POWER_STATUS    8'h20
`define SPM_OFS_FIFO_READ_PORT  8'h24

////////////////////////////////////////////////////////////////////////////////
// field positions
`define SPM_BIT_DEEP_SAVE       0
`define SPM_BIT_FIFO_AUTOWAKE   1
`define SPM_BIT_AUX_EN          0
`define SPM_BIT_ACCEL_EN        2
`define SPM_BIT_PERF_SEL        7
`define SPM_BIT_ERR_SPACING     8
`define SPM_BIT_ERR_REENABLE    9
`define SPM_BIT_ERR_ODD_BURST   10
`define SPM_BIT_FIFO_AWAKE      4

////////////////////////////////////////////////////////////////////////////////
// reset values and codes
`define SPM_RST_PWR_STATE_CFG   2'h1
`define SPM_RST_SENSOR_PWR_EN   3'h0
`define SPM_RST_ACCEL_CFG       8'h00
`define SPM_LOAD_START          8'h00
`define SPM_LOAD_ENABLE         8'h01
`define SPM_ENGINE_READY_CODE   4'h1

////////////////////////////////////////////////////////////////////////////////
// timing
`define SPM_CLK_NS              20
`define SPM_CLK_KHZ             50000
`define SPM_TICK_NS             39250
`define SPM_ENGINE_READY_MS     150
`define SPM_LP_WRITE_GAP_US     450

`endif

// >>> rtl/spm_pkg.sv
// types of the power-mode controller
package spm_pkg;

    typedef enum logic [1:0] {
        SPM_MODE_CONFIG  = 2'h0,
        SPM_MODE_SUSPEND = 2'h1,
        SPM_MODE_LOWPWR  = 2'h3,
        SPM_MODE_PERF    = 2'h2
    } spm_mode_e;

    typedef enum logic [1:0] {
        SPM_ENG_IDLE  = 2'h0,
        SPM_ENG_BUSY  = 2'h1,
        SPM_ENG_READY = 2'h3
    } spm_eng_e;

endpackage : spm_pkg

// >>> rtl/spm_win_if.sv
// feature window access between controller and image store
`timescale 1ns/1ps
interface spm_win_if #(
    parameter int AW = 6
);
    logic          wr;
    logic          rd;
    logic          clr;
    logic          set;
    logic [15:0]   wdata;
    logic [AW-1:0] sidx;
    logic [15:0]   rdata;
    logic [AW-1:0] idx;

    modport ctrl (output wr, output rd, output clr, output set, output wdata, output sidx,
                  input rdata, input idx);
    modport mem  (input wr, input rd, input clr, input set, input wdata, input sidx,
                  output rdata, output idx);
endinterface : spm_win_if

// >>> rtl/spm_time_ctr.sv
// free-running sensor-time counter with fractional prescaler
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_time_ctr #(
    parameter int W = 24
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    output logic      [W-1:0] count_o
);
    import spm_pkg::*;

    localparam logic [15:0] STEP = 16'(`SPM_CLK_NS);
    localparam logic [15:0] TICK = 16'(`SPM_TICK_NS);

    logic [15:0] acc;
    wire  [15:0] acc_sum = acc + STEP;
    wire         tick    = (acc_sum >= TICK);
    wire  [15:0] next_acc = tick ? (acc_sum - TICK) : acc_sum;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc     <= 16'h0000;
            count_o <= '0;
        end else begin
            acc <= next_acc;
            if (tick) begin
                count_o <= count_o + W'(1);
            end
        end
    end
endmodule : spm_time_ctr

// >>> rtl/spm_feat_mem.sv
// feature configuration image store with auto-advancing index
`timescale 1ns/1ps
module spm_feat_mem #(
    parameter int AW = 6
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    spm_win_if.mem    win
);
    import spm_pkg::*;

    logic [15:0]   store [2**AW];
    logic [AW-1:0] idx;

    assign win.idx   = idx;
    assign win.rdata = store[idx];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx <= '0;
        end else if (win.clr) begin
            idx <= '0;
        end else if (win.set) begin
            idx <= win.sidx;
        end else if (win.wr || win.rd) begin
            idx <= idx + AW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (win.wr) begin
            store[idx] <= win.wdata;
        end
    end
endmodule : spm_feat_mem

// >>> rtl/spm_power_ctrl.sv
// power-mode and start-up controller with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "spm_cfg.svh"

//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - reset leaves deep power-save set, sensors off: suspend; host reruns start-up.
// - sensor-time counter low byte advances every 39.25 us.
// - image may arrive in several bursts; each burst an even byte count.
// - loaded image can be read back through the same window.
// - engine status reads 1 within 150 ms of enabling; host polls it.
// - after start-up the device sits in configuration mode; any mode reachable.
// - sensor enable register switches sensors; power-state register picks their state.
// - power state never changes data quality; only accel config does.
// - registers and FIFO contents kept in every power configuration.
// - low power when deep power-save is 1, accel is enabled and performance select is 0.
// - samples logged into FIFO in performance and low power.
// - low power, watermark, auto-wake: FIFO readable until a burst read ends.
// - mode decode: config, suspend, performance, low power from three bits.
// - all sensors off after reset; accel runs only once enabled.
module spm_power_ctrl #(
    parameter int ENGINE_READY_CYCLES = `SPM_ENGINE_READY_MS * `SPM_CLK_KHZ,
    parameter int LP_WRITE_GAP_CYCLES = (`SPM_LP_WRITE_GAP_US * `SPM_CLK_KHZ + 999) / 1000,
    parameter int IMG_AW              = 6
)(
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    input  wire logic [7:0]        AVS_ADDRESS_I,
    input  wire logic              AVS_READ_I,
    input  wire logic              AVS_WRITE_I,
    input  wire logic [31:0]       AVS_WRITEDATA_I,
    input  wire logic [3:0]        AVS_BYTEENABLE_I,
    output logic      [31:0]       AVS_READDATA_O,
    output logic      [1:0]        AVS_RESPONSE_O,
    output logic                   AVS_WAITREQUEST_O,
    input  wire logic              FIFO_WATERMARK_I,
    input  wire logic [7:0]        FIFO_DATA_I,
    output logic                   FIFO_POP_O,
    output logic                   FIFO_LOG_EN_O,
    output logic                   FIFO_AWAKE_O,
    output logic                   ACCEL_ENABLE_O,
    output logic                   AUX_ENABLE_O,
    output logic      [7:0]        ACCEL_CONFIG_O,
    output spm_pkg::spm_mode_e     POWER_MODE_O,
    output logic                   FEATURE_ENGINE_O
);
    import spm_pkg::*;

    localparam int CW = $clog2(ENGINE_READY_CYCLES + 1);
    localparam int GW = $clog2(LP_WRITE_GAP_CYCLES + 1);

    //////////////////////////////////////////////////////////////////////////////////////
    // state
    logic          deep_save;
    logic          fifo_autowake;
    logic          aux_en;
    logic          accel_en;
    logic [7:0]    accel_config;
    spm_eng_e      eng_state;
    logic [CW-1:0] eng_cnt;
    logic          eng_enabled_once;
    logic          err_spacing;
    logic          err_reenable;
    logic          err_odd;
    logic [GW-1:0] gap_cnt;
    logic          fifo_awake;
    logic          fifo_burst;
    logic          watermark_q;
    logic [23:0]   time_count;

    spm_win_if #(.AW(IMG_AW)) win ();

    spm_time_ctr #(.W(24)) u_time (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .count_o (time_count)
    );

    spm_feat_mem #(.AW(IMG_AW)) u_mem (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .win   (win)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req      = AVS_READ_I | AVS_WRITE_I;
    wire take     = req & ~AVS_WAITREQUEST_O;
    wire wr_take  = AVS_WRITE_I & take;
    wire rd_take  = AVS_READ_I & take;
    wire [7:0] wd = AVS_WRITEDATA_I[7:0];
    wire be0      = AVS_BYTEENABLE_I[0];

    wire sel_psc  = (AVS_ADDRESS_I == `SPM_OFS_PWR_STATE_CFG);
    wire sel_spe  = (AVS_ADDRESS_I == `SPM_OFS_SENSOR_PWR_EN);
    wire sel_acc  = (AVS_ADDRESS_I == `SPM_OFS_ACCEL_CFG);
    wire sel_load = (AVS_ADDRESS_I == `SPM_OFS_FEAT_LOAD_CTRL);
    wire sel_win  = (AVS_ADDRESS_I == `SPM_OFS_FEAT_WINDOW);
    wire sel_idx  = (AVS_ADDRESS_I == `SPM_OFS_FEAT_INDEX);
    wire sel_eng  = (AVS_ADDRESS_I == `SPM_OFS_ENGINE_STATUS);
    wire sel_time = (AVS_ADDRESS_I == `SPM_OFS_TIME_COUNTER);
    wire sel_pst  = (AVS_ADDRESS_I == `SPM_OFS_POWER_STATUS);
    wire sel_fifo = (AVS_ADDRESS_I == `SPM_OFS_FIFO_READ_PORT);
    wire mapped   = sel_psc | sel_spe | sel_acc | sel_load | sel_win | sel_idx | sel_eng
                  | sel_time | sel_pst | sel_fifo;

    //////////////////////////////////////////////////////////////////////////////////////
    // power mode decode
    // mode table
    wire perf_sel = accel_config[`SPM_BIT_PERF_SEL];
    spm_mode_e next_mode;
    assign next_mode = ~deep_save ? SPM_MODE_CONFIG :
                       ~accel_en  ? SPM_MODE_SUSPEND :
                       perf_sel   ? SPM_MODE_PERF : SPM_MODE_LOWPWR;
    wire in_lowpwr   = (next_mode == SPM_MODE_LOWPWR);

    //////////////////////////////////////////////////////////////////////////////////////
    // feature window and load control
    wire load_wr      = wr_take & sel_load & be0;
    wire load_start   = load_wr & (wd == `SPM_LOAD_START);
    wire load_enable  = load_wr & (wd == `SPM_LOAD_ENABLE);
    // halfword pairs; single byte lanes refused
    wire win_pair     = (AVS_BYTEENABLE_I[1:0] == 2'h3);
    wire win_wr       = wr_take & sel_win & win_pair;
    wire odd_event    = wr_take & sel_win & ~win_pair;

    assign win.clr   = load_start;
    assign win.wr    = win_wr;
    assign win.rd    = rd_take & sel_win;
    assign win.set   = wr_take & sel_idx & be0;
    assign win.wdata = AVS_WRITEDATA_I[15:0];
    assign win.sidx  = AVS_WRITEDATA_I[IMG_AW-1:0];

    //////////////////////////////////////////////////////////////////////////////////////
    // error and fifo events
    wire spacing_event  = wr_take & in_lowpwr & (gap_cnt != '0);
    wire reenable_event = load_enable & eng_enabled_once;
    wire clr_pst        = wr_take & sel_pst & AVS_BYTEENABLE_I[1];
    wire wm_rise        = FIFO_WATERMARK_I & ~watermark_q;
    // readable when awake, in performance or not saving
    wire fifo_readable  = ~deep_save | (next_mode == SPM_MODE_PERF) | fifo_awake;
    wire fifo_rd        = rd_take & sel_fifo & fifo_readable;
    wire burst_end      = take & ~sel_fifo & fifo_burst;

    //////////////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [31:0] rd_mux;
    assign rd_mux =
        sel_psc  ? {30'h0, fifo_autowake, deep_save} :
        sel_spe  ? {29'h0, accel_en, 1'b0, aux_en} :
        sel_acc  ? {24'h0, accel_config} :
        sel_load ? {31'h0, eng_enabled_once} :
        sel_win  ? {16'h0, win.rdata} :
        sel_idx  ? {{(32-IMG_AW){1'b0}}, win.idx} :
        sel_eng  ? {28'h0, (eng_state == SPM_ENG_READY) ? `SPM_ENGINE_READY_CODE : 4'h0} :
        sel_time ? {8'h0, time_count} :
        sel_pst  ? {21'h0, err_odd, err_reenable, err_spacing, 3'h0, fifo_awake, 2'h0,
                    next_mode} :
        sel_fifo ? {24'h0, fifo_readable ? FIFO_DATA_I : 8'h00} :
        32'h0;

    //////////////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= 32'h0;
            AVS_RESPONSE_O    <= 2'h0;
        end else begin
            AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
            if (req & AVS_WAITREQUEST_O) begin
                AVS_READDATA_O <= AVS_READ_I ? rd_mux : 32'h0;
                AVS_RESPONSE_O <= mapped ? 2'h0 : 2'h3;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            {fifo_autowake, deep_save} <= `SPM_RST_PWR_STATE_CFG;
            {accel_en, aux_en}         <= 2'h0;
            accel_config               <= `SPM_RST_ACCEL_CFG;
        end else begin
            if (wr_take & sel_psc & be0) begin
                deep_save     <= wd[`SPM_BIT_DEEP_SAVE];
                fifo_autowake <= wd[`SPM_BIT_FIFO_AUTOWAKE];
            end
            if (wr_take & sel_spe & be0) begin
                aux_en   <= wd[`SPM_BIT_AUX_EN];
                accel_en <= wd[`SPM_BIT_ACCEL_EN];
            end
            if (wr_take & sel_acc & be0) begin
                accel_config <= wd;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // feature engine
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            eng_state        <= SPM_ENG_IDLE;
            eng_cnt          <= '0;
            eng_enabled_once <= 1'b0;
        end else begin
            unique case (eng_state)
                SPM_ENG_IDLE: begin
                    if (load_enable & ~eng_enabled_once) begin
                        eng_state        <= SPM_ENG_BUSY;
                        eng_cnt          <= '0;
                        eng_enabled_once <= 1'b1;
                    end
                end
                SPM_ENG_BUSY: begin
                    if (eng_cnt == CW'(ENGINE_READY_CYCLES - 1)) begin
                        eng_state <= SPM_ENG_READY;
                    end else begin
                        eng_cnt <= eng_cnt + CW'(1);
                    end
                end
                SPM_ENG_READY: begin
                    eng_state <= SPM_ENG_READY;
                end
                default: begin
                    eng_state <= SPM_ENG_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // sticky errors: set wins over write-one clear
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            err_spacing  <= 1'b0;
            err_reenable <= 1'b0;
            err_odd      <= 1'b0;
            gap_cnt      <= '0;
        end else begin
            err_spacing  <= spacing_event
                          | (err_spacing & ~(clr_pst & AVS_WRITEDATA_I[`SPM_BIT_ERR_SPACING]));
            err_reenable <= reenable_event
                          | (err_reenable & ~(clr_pst & AVS_WRITEDATA_I[`SPM_BIT_ERR_REENABLE]));
            err_odd      <= odd_event
                          | (err_odd & ~(clr_pst & AVS_WRITEDATA_I[`SPM_BIT_ERR_ODD_BURST]));
            if (wr_take & in_lowpwr) begin
                gap_cnt <= GW'(LP_WRITE_GAP_CYCLES);
            end else if (gap_cnt != '0) begin
                gap_cnt <= gap_cnt - GW'(1);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // fifo wake window
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            watermark_q <= 1'b0;
            fifo_awake  <= 1'b0;
            fifo_burst  <= 1'b0;
            FIFO_POP_O  <= 1'b0;
        end else begin
            watermark_q <= FIFO_WATERMARK_I;
            FIFO_POP_O  <= fifo_rd;
            // open on watermark, close at burst end
            if (wm_rise & in_lowpwr & fifo_autowake) begin
                fifo_awake <= 1'b1;
            end else if (burst_end | ~in_lowpwr) begin
                fifo_awake <= 1'b0;
            end
            if (fifo_rd) begin
                fifo_burst <= 1'b1;
            end else if (take) begin
                fifo_burst <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            POWER_MODE_O     <= SPM_MODE_SUSPEND;
            ACCEL_ENABLE_O   <= 1'b0;
            AUX_ENABLE_O     <= 1'b0;
            ACCEL_CONFIG_O   <= `SPM_RST_ACCEL_CFG;
            FIFO_LOG_EN_O    <= 1'b0;
            FIFO_AWAKE_O     <= 1'b0;
            FEATURE_ENGINE_O <= 1'b0;
        end else begin
            POWER_MODE_O     <= next_mode;
            ACCEL_ENABLE_O   <= accel_en;
            AUX_ENABLE_O     <= aux_en;
            ACCEL_CONFIG_O   <= accel_config;
            // logging in performance and low power
            FIFO_LOG_EN_O    <= (next_mode == SPM_MODE_PERF) | in_lowpwr;
            FIFO_AWAKE_O     <= fifo_awake;
            FEATURE_ENGINE_O <= (eng_state == SPM_ENG_READY);
        end
    end

endmodule : spm_power_ctrl

// >>> testbench/spm_power_ctrl_monitor.sv
// port assertions of the power-mode controller
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_power_ctrl_monitor (
    input wire logic               CLK_I,
    input wire logic               RST_I,
    input wire logic [7:0]         AVS_ADDRESS_I,
    input wire logic               AVS_READ_I,
    input wire logic               AVS_WRITE_I,
    input wire logic [31:0]        AVS_WRITEDATA_I,
    input wire logic [3:0]         AVS_BYTEENABLE_I,
    input wire logic [1:0]         AVS_RESPONSE_O,
    input wire logic               AVS_WAITREQUEST_O,
    input wire logic               FIFO_POP_O,
    input wire logic               FIFO_LOG_EN_O,
    input wire logic               ACCEL_ENABLE_O,
    input wire logic               AUX_ENABLE_O,
    input wire logic [7:0]         ACCEL_CONFIG_O,
    input wire spm_pkg::spm_mode_e POWER_MODE_O,
    input wire logic               FEATURE_ENGINE_O
);
    import spm_pkg::*;
    default clocking mon_cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    wire take    = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
    wire wr_take = take && AVS_WRITE_I;
    ////////////////////////////////////////
    AST_RESET_SUSPEND: assert property ($past(RST_I) |-> POWER_MODE_O == SPM_MODE_SUSPEND && !ACCEL_ENABLE_O)
        else $error("no suspend");
    AST_WAIT_ANSWER: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("no answer");
    AST_WAIT_ONE: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
        else $error("long answer");
    AST_UNMAPPED: assert property (take && AVS_ADDRESS_I > `SPM_OFS_FIFO_READ_PORT |-> AVS_RESPONSE_O == 2'h3)
        else $error("no decode error");
    AST_POP_CAUSE: assert property (FIFO_POP_O |-> $past(take && AVS_READ_I
        && AVS_ADDRESS_I == `SPM_OFS_FIFO_READ_PORT) ##1 !FIFO_POP_O) else $error("stray pop");
    AST_ENABLE_COPY: assert property (wr_take && AVS_ADDRESS_I == `SPM_OFS_SENSOR_PWR_EN && AVS_BYTEENABLE_I[0]
        |-> ##2 {ACCEL_ENABLE_O, AUX_ENABLE_O} == $past({AVS_WRITEDATA_I[2], AVS_WRITEDATA_I[0]}, 2))
        else $error("enables stale");
    AST_CONFIG_COPY: assert property (wr_take && AVS_ADDRESS_I == `SPM_OFS_ACCEL_CFG && AVS_BYTEENABLE_I[0]
        |-> ##2 ACCEL_CONFIG_O == $past(AVS_WRITEDATA_I[7:0], 2)) else $error("config stale");
    AST_LOG_EN: assert property ($stable(POWER_MODE_O) |-> FIFO_LOG_EN_O == POWER_MODE_O[1])
        else $error("logging wrong");
    AST_ENGINE_HOLD: assert property (FEATURE_ENGINE_O |=> FEATURE_ENGINE_O)
        else $error("ready dropped");
    AST_PERF_DECODE: assert property ($stable({ACCEL_ENABLE_O, ACCEL_CONFIG_O}) && POWER_MODE_O == SPM_MODE_PERF
        |-> ACCEL_ENABLE_O && ACCEL_CONFIG_O[7]) else $error("bad perf decode");
endmodule : spm_power_ctrl_monitor

bind spm_power_ctrl spm_power_ctrl_monitor mon (
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_RESPONSE_O(AVS_RESPONSE_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .FIFO_POP_O(FIFO_POP_O), .FIFO_LOG_EN_O(FIFO_LOG_EN_O), .ACCEL_ENABLE_O(ACCEL_ENABLE_O),
    .AUX_ENABLE_O(AUX_ENABLE_O), .ACCEL_CONFIG_O(ACCEL_CONFIG_O), .POWER_MODE_O(POWER_MODE_O),
    .FEATURE_ENGINE_O(FEATURE_ENGINE_O)
);

// >>> testbench/spm_fifo_model.sv
// sample fifo model: head byte and watermark
`timescale 1ns/1ps
module spm_fifo_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       pop_i,
    input  wire logic       fill_i,
    output logic            watermark_o,
    output logic [7:0]      data_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            watermark_o <= 1'b0;
            data_o      <= 8'hA5;
        end else begin
            watermark_o <= fill_i;
            if (pop_i) data_o <= data_o + 8'h13;
        end
    end
endmodule : spm_fifo_model

// >>> testbench/spm_power_ctrl_bench.sv
// self-checking bench of the power-mode controller
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_power_ctrl_bench;
    import spm_pkg::*;
    localparam int ENG = 20;
    localparam int GAP = 8;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  avs_addr = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_wdata = 32'h0;
    logic [3:0]  avs_be = 4'h0;
    logic        fill = 1'b0;
    logic [31:0] rdata, got, t0;
    logic [1:0]  resp;
    logic        waitreq, wm, pop, log_en, awake, acc_en, aux_en, engine;
    logic [7:0]  fdata, acc_cfg;
    logic [7:0]  fexp = 8'hA5;
    spm_mode_e   mode, em;
    logic [34:0] exp_q[$];
    logic [34:0] note;
    logic [15:0] rnd = 16'h0013;
    logic [15:0] img[8];
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    always #10 clk_i = ~clk_i;
    spm_power_ctrl #(.ENGINE_READY_CYCLES(ENG), .LP_WRITE_GAP_CYCLES(GAP)) dut (
        .CLK_I(clk_i), .RST_I(rst_i), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_read),
        .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(avs_be),
        .AVS_READDATA_O(rdata), .AVS_RESPONSE_O(resp), .AVS_WAITREQUEST_O(waitreq),
        .FIFO_WATERMARK_I(wm), .FIFO_DATA_I(fdata), .FIFO_POP_O(pop), .FIFO_LOG_EN_O(log_en),
        .FIFO_AWAKE_O(awake), .ACCEL_ENABLE_O(acc_en), .AUX_ENABLE_O(aux_en), .ACCEL_CONFIG_O(acc_cfg),
        .POWER_MODE_O(mode), .FEATURE_ENGINE_O(engine)
    );
    spm_fifo_model fifo (.clk_i(clk_i), .rst_i(rst_i), .pop_i(pop), .fill_i(fill), .watermark_o(wm), .data_o(fdata));
    ////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : check
    task automatic give_verdict();
        $display("tests %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_write <= w;
        avs_read  <= !w;
        avs_addr  <= a;
        avs_wdata <= d;
        avs_be    <= be;
        do @(posedge clk_i); while (waitreq !== 1'b0);
        got = rdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        bus(1'b1, a, d, be);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0, input logic c = 1'b1);
        exp_q.push_back({r, c, e});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    task automatic idle(input int n);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : idle
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (avs_read === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[32]) check(rdata, note[31:0]);
            check(32'(resp), 32'(note[34:33]));
        end
        if (cycles == 12000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(mode), 32'(SPM_MODE_SUSPEND));
        check({31'h0, acc_en | aux_en}, 32'h0);
        rd(`SPM_OFS_PWR_STATE_CFG, 32'h1);
        rd(`SPM_OFS_SENSOR_PWR_EN, 32'h0);
        rd(`SPM_OFS_ACCEL_CFG, 32'h0);
        rd(8'h40, 32'h0, 2'h3);
        $display("test reset done");
        wr(`SPM_OFS_PWR_STATE_CFG, 32'h0);
        rd(`SPM_OFS_TIME_COUNTER, 32'h0, 2'h0, 1'b0);
        t0 = got;
        idle(3923);
        rd(`SPM_OFS_TIME_COUNTER, 32'h0, 2'h0, 1'b0);
        check({24'h0, got[7:0] - t0[7:0]}, 32'h2);
        wr(`SPM_OFS_FEAT_LOAD_CTRL, {24'h0, `SPM_LOAD_START});
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            img[i] = rnd;
            wr(`SPM_OFS_FEAT_WINDOW, {16'h0, rnd}, 4'h3);
            if (i == 3) idle(2);
        end
        wr(`SPM_OFS_FEAT_WINDOW, 32'hFF, 4'h1);
        rd(`SPM_OFS_FEAT_INDEX, 32'h8);
        wr(`SPM_OFS_FEAT_INDEX, 32'h0);
        for (int i = 0; i < 8; i++) rd(`SPM_OFS_FEAT_WINDOW, {16'h0, img[i]});
        wr(`SPM_OFS_FEAT_LOAD_CTRL, {24'h0, `SPM_LOAD_ENABLE});
        idle(16);
        rd(`SPM_OFS_ENGINE_STATUS, 32'h0);
        idle(4);
        rd(`SPM_OFS_ENGINE_STATUS, {28'h0, `SPM_ENGINE_READY_CODE});
        wr(`SPM_OFS_FEAT_LOAD_CTRL, {24'h0, `SPM_LOAD_ENABLE});
        rd(`SPM_OFS_POWER_STATUS, 32'h600);
        check({31'h0, engine}, 32'h1);
        wr(`SPM_OFS_POWER_STATUS, 32'h700);
        rd(`SPM_OFS_POWER_STATUS, 32'h0);
        $display("test startup done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(`SPM_OFS_ACCEL_CFG, {24'h0, i[2], rnd[6:0]});
            idle(GAP + 2);
            wr(`SPM_OFS_SENSOR_PWR_EN, {29'h0, i[1], 1'b0, rnd[8]});
            idle(GAP + 2);
            wr(`SPM_OFS_PWR_STATE_CFG, {31'h0, i[0]});
            em = !i[0] ? SPM_MODE_CONFIG : !i[1] ? SPM_MODE_SUSPEND : i[2] ? SPM_MODE_PERF : SPM_MODE_LOWPWR;
            rd(`SPM_OFS_POWER_STATUS, {30'h0, em});
            idle(GAP + 2);
            check({21'h0, log_en, acc_en, aux_en, acc_cfg}, {21'h0, em[1], i[1], rnd[8], i[2], rnd[6:0]});
            check(32'(mode), 32'(em));
        end
        $display("test modes done");
        wr(`SPM_OFS_ACCEL_CFG, 32'h0);
        wr(`SPM_OFS_ACCEL_CFG, 32'h5);
        wr(`SPM_OFS_ACCEL_CFG, 32'h5);
        rd(`SPM_OFS_POWER_STATUS, 32'h103);
        idle(GAP + 2);
        wr(`SPM_OFS_POWER_STATUS, 32'h100, 4'h2);
        idle(GAP + 2);
        wr(`SPM_OFS_PWR_STATE_CFG, 32'h3);
        rd(`SPM_OFS_POWER_STATUS, 32'h3);
        rd(`SPM_OFS_FIFO_READ_PORT, 32'h0);
        fill <= 1'b1;
        idle(5);
        check({31'h0, awake}, 32'h1);
        rd(`SPM_OFS_FIFO_READ_PORT, {24'h0, fexp});
        idle(2);
        fexp = fexp + 8'h13;
        rd(`SPM_OFS_FIFO_READ_PORT, {24'h0, fexp});
        idle(2);
        rd(`SPM_OFS_PWR_STATE_CFG, 32'h3);
        rd(`SPM_OFS_FIFO_READ_PORT, 32'h0);
        wr(`SPM_OFS_PWR_STATE_CFG, 32'h0);
        idle(GAP);
        rd(`SPM_OFS_FIFO_READ_PORT, {24'h0, fexp + 8'h13});
        $display("test fifo done");
        idle(2);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(mode), 32'(SPM_MODE_SUSPEND));
        rd(`SPM_OFS_ENGINE_STATUS, 32'h0);
        wr(`SPM_OFS_FEAT_LOAD_CTRL, {24'h0, `SPM_LOAD_ENABLE});
        idle(ENG + 4);
        rd(`SPM_OFS_ENGINE_STATUS, 32'h1);
        rd(`SPM_OFS_POWER_STATUS, 32'h1);
        idle(2);
        $display("test soft reset done");
        give_verdict();
    end
endmodule : spm_power_ctrl_bench
